//--- hw/debug_gate_defs.svh
`ifndef DEBUG_GATE_DEFS_SVH
`define DEBUG_GATE_DEFS_SVH

// =====================================================================
// Register map (byte addresses)
`define DG_ADDR_W        5
`define DG_OFS_CTRL      5'h00
`define DG_OFS_ID0       5'h04
`define DG_OFS_ID1       5'h08
`define DG_OFS_ID2       5'h0C
`define DG_OFS_STATUS    5'h10

// =====================================================================
// Control fields
`define DG_CTRL_AUTH     0
`define DG_CTRL_RELOCK   1
`define DG_CTRL_FAILCLR  2
`define DG_CTRL_LINK_LO  4
`define DG_CTRL_LINK_HI  5

// =====================================================================
// Status fields
`define DG_ST_UNLOCKED   0
`define DG_ST_EMU_FLAG   1
`define DG_ST_ENABLED    2
`define DG_ST_FAIL       3
`define DG_ST_BREAK_OK   4
`define DG_ST_MON_OK     5

// =====================================================================
// Stored code layout and reset values
`define DG_ID_BYTES      10
`define DG_ID_FIRST_ADDR 8'h70
`define DG_ID_LAST_ADDR  8'h79
`define DG_EMU_FLAG_BIT  79
`define DG_RST_WORD      32'h0000_0000
`define DG_RST_HALF      16'h0000
`define DG_RESP_OKAY     2'b00
`define DG_RESP_SLVERR   2'b10

`endif

//--- hw/debug_gate_pkg.sv
package debug_gate_pkg;

  typedef enum logic [1:0] {
    AUTH_LOCKED = 2'b00,
    AUTH_CHECK  = 2'b01,
    AUTH_OPEN   = 2'b10,
    AUTH_DENIED = 2'b11
  } auth_state_t;

  typedef enum logic [1:0] {
    LINK_CSI0 = 2'b00,
    LINK_CSI3 = 2'b01,
    LINK_UART = 2'b10,
    LINK_RSVD = 2'b11
  } link_mode_t;

  typedef struct packed {
    auth_state_t auth;
    link_mode_t  link;
    logic        fail;
    logic [31:0] id0;
    logic [31:0] id1;
    logic [15:0] id2;
    logic        aw_got;
    logic        w_got;
    logic [4:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        debug_enabled;
    logic        break_grant;
    logic        monitor_grant;
    logic        monitor_write_reject;
    logic        standby_wake;
    logic        flash_read_valid;
    logic [31:0] flash_rdata;
  } gate_state_t;

endpackage

//--- hw/id_code_compare.sv
`timescale 1ns/1ps
`include "debug_gate_defs.svh"

module id_code_compare #(
  parameter int BYTES = `DG_ID_BYTES
) (
  input  wire logic [8*BYTES-1:0] stored_id,
  input  wire logic [8*BYTES-1:0] supplied_id,
  output logic                    match
);

  logic [BYTES-1:0] byte_eq;

  // =====================================================================
  // Byte-wise compare, byte 0 is the lowest flash address
  genvar i;
  generate
    for (i = 0; i < BYTES; i++) begin : g_byte
      assign byte_eq[i] = (stored_id[8*i +: 8] == supplied_id[8*i +: 8]);
    end
  endgenerate

  assign match = &byte_eq;

endmodule

//--- hw/debug_access_security_gate.sv
// Summary of operation
// - Compare ten stored flash bytes with host code
// - Match with flag set lifts protection for flash and emulator
// - Bit 7 of last byte permits emulator
// - Flag clear refuses debug despite matching code
// - Forced break blocked under four conditions
// - Monitor and modify also blocked on clock mismatch in UART link mode
// - Monitor requests wake device from standby
// - Protected peripheral writes refused over debug path
`timescale 1ns/1ps
`include "debug_gate_defs.svh"

module debug_access_security_gate (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [79:0] stored_id,
  input  wire logic        global_interrupt_disable,
  input  wire logic        debug_irq_masked,
  input  wire logic        standby_active,
  input  wire logic        standby_maskable_wake_off,
  input  wire logic        main_clock_running,
  input  wire logic        uart_clock_mismatch,
  input  wire logic        break_req,
  input  wire logic        monitor_req,
  input  wire logic        monitor_write,
  input  wire logic        monitor_target_protected,
  input  wire logic        flash_read_req,
  input  wire logic [31:0] flash_rdata_in,
  output logic             debug_enabled,
  output logic             break_grant,
  output logic             monitor_grant,
  output logic             monitor_write_reject,
  output logic             standby_wake,
  output logic             flash_read_valid,
  output logic [31:0]      flash_rdata
);

  debug_gate_pkg::gate_state_t s_q;
  debug_gate_pkg::gate_state_t s_d;
  logic                        id_match;
  logic                        emu_flag;
  logic                        brk_block;
  logic                        mon_block;

  // =====================================================================
  // Helpers
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic break_blocked(input logic gid, input logic masked, input logic stby,
                                         input logic wake_off, input debug_gate_pkg::link_mode_t lm,
                                         input logic clk_run);
    return gid || masked || (stby && wake_off) || (lm == debug_gate_pkg::LINK_UART && !clk_run);
  endfunction

  // =====================================================================
  // Code comparison
  id_code_compare #(
    .BYTES       (`DG_ID_BYTES)
  ) u_cmp (
    .stored_id   (stored_id),
    .supplied_id ({s_q.id2, s_q.id1, s_q.id0}),
    .match       (id_match)
  );

  assign emu_flag  = stored_id[`DG_EMU_FLAG_BIT];
  assign brk_block = break_blocked(global_interrupt_disable, debug_irq_masked, standby_active,
                                   standby_maskable_wake_off, s_q.link, main_clock_running);
  assign mon_block = brk_block || (s_q.link == debug_gate_pkg::LINK_UART && uart_clock_mismatch);

  // =====================================================================
  // Next state
  always_comb begin
    logic       wr_fire;
    logic [2:0] widx;
    logic [2:0] ridx;
    logic       en;
    logic [31:0] id2_w;
    wr_fire = 1'b0;
    id2_w   = 32'h0000_0000;
    widx    = 3'h0;
    ridx    = 3'h0;
    en      = (s_q.auth == debug_gate_pkg::AUTH_OPEN);
    s_d     = s_q;

    // Write address and data may arrive in either order
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
      wr_fire    = 1'b1;
      widx       = s_q.awaddr[4:2];
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = (widx <= 3'h4) ? `DG_RESP_OKAY : `DG_RESP_SLVERR;
    end

    // Authentication sequence
    case (s_q.auth)
      debug_gate_pkg::AUTH_CHECK: begin
        if (id_match && emu_flag) begin
          s_d.auth = debug_gate_pkg::AUTH_OPEN;
        end else begin
          s_d.auth = debug_gate_pkg::AUTH_DENIED;
          s_d.fail = 1'b1;
        end
      end
      debug_gate_pkg::AUTH_LOCKED, debug_gate_pkg::AUTH_OPEN, debug_gate_pkg::AUTH_DENIED: begin
        s_d.auth = s_q.auth;
      end
      default: begin
        s_d.auth = debug_gate_pkg::AUTH_LOCKED;
      end
    endcase

    if (wr_fire) begin
      case (widx)
        3'h0: begin
          s_d.link = debug_gate_pkg::link_mode_t'(s_q.wdata[`DG_CTRL_LINK_HI:`DG_CTRL_LINK_LO]);
          if (s_q.wdata[`DG_CTRL_FAILCLR] && !(s_q.auth == debug_gate_pkg::AUTH_CHECK)) begin
            s_d.fail = 1'b0;
          end
          if (s_q.wdata[`DG_CTRL_RELOCK]) begin
            s_d.auth = debug_gate_pkg::AUTH_LOCKED;
          end
          if (s_q.wdata[`DG_CTRL_AUTH]) begin
            s_d.auth = debug_gate_pkg::AUTH_CHECK;
          end
        end
        3'h1: s_d.id0 = merge_bytes(s_q.id0, s_q.wdata, s_q.wstrb);
        3'h2: s_d.id1 = merge_bytes(s_q.id1, s_q.wdata, s_q.wstrb);
        3'h3: begin
          id2_w   = merge_bytes({16'h0000, s_q.id2}, s_q.wdata, s_q.wstrb);
          s_d.id2 = id2_w[15:0];
        end
        default: begin
          s_d.id2 = s_q.id2;
        end
      endcase
    end

    s_d.awready = !s_d.aw_got && !s_d.bvalid;
    s_d.wready  = !s_d.w_got && !s_d.bvalid;

    // Read channel
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_q.arready) begin
      ridx       = s_axi_araddr[4:2];
      s_d.rvalid = 1'b1;
      s_d.rresp  = `DG_RESP_OKAY;
      case (ridx)
        3'h0: s_d.rdata = {26'h0, s_q.link, 4'h0};
        3'h1: s_d.rdata = s_q.id0;
        3'h2: s_d.rdata = s_q.id1;
        3'h3: s_d.rdata = {16'h0000, s_q.id2};
        3'h4: s_d.rdata = {26'h0, !mon_block, !brk_block, s_q.fail, en, emu_flag, en};
        default: begin
          s_d.rdata = 32'h0000_0000;
          s_d.rresp = `DG_RESP_SLVERR;
        end
      endcase
    end
    s_d.arready = !s_d.rvalid;

    // Debug path, one registered cycle after each request
    s_d.debug_enabled        = en;
    s_d.break_grant          = break_req && en && !brk_block;
    s_d.monitor_write_reject = monitor_req && monitor_write && monitor_target_protected;
    s_d.monitor_grant        = monitor_req && en && !mon_block &&
                               !(monitor_write && monitor_target_protected);
    s_d.standby_wake         = monitor_req && en && standby_active && !standby_maskable_wake_off &&
                               (s_q.link != debug_gate_pkg::LINK_UART || main_clock_running);
    s_d.flash_read_valid     = flash_read_req;
    s_d.flash_rdata          = (flash_read_req && en) ? flash_rdata_in : 32'h0000_0000;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q         <= '0;
      s_q.auth    <= debug_gate_pkg::AUTH_LOCKED;
      s_q.link    <= debug_gate_pkg::LINK_CSI0;
      s_q.id0     <= `DG_RST_WORD;
      s_q.id1     <= `DG_RST_WORD;
      s_q.id2     <= `DG_RST_HALF;
      s_q.awready <= 1'b1;
      s_q.wready  <= 1'b1;
      s_q.arready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready        = s_q.awready;
  assign s_axi_wready         = s_q.wready;
  assign s_axi_bvalid         = s_q.bvalid;
  assign s_axi_bresp          = s_q.bresp;
  assign s_axi_arready        = s_q.arready;
  assign s_axi_rvalid         = s_q.rvalid;
  assign s_axi_rresp          = s_q.rresp;
  assign s_axi_rdata          = s_q.rdata;
  assign debug_enabled        = s_q.debug_enabled;
  assign break_grant          = s_q.break_grant;
  assign monitor_grant        = s_q.monitor_grant;
  assign monitor_write_reject = s_q.monitor_write_reject;
  assign standby_wake         = s_q.standby_wake;
  assign flash_read_valid     = s_q.flash_read_valid;
  assign flash_rdata          = s_q.flash_rdata;

  // =====================================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence check_pass_s;
    s_q.auth == debug_gate_pkg::AUTH_CHECK && id_match && emu_flag;
  endsequence

  sequence check_fail_s;
    s_q.auth == debug_gate_pkg::AUTH_CHECK && !(id_match && emu_flag);
  endsequence

  auth_open_a: assert property (check_pass_s |=> ##1 debug_enabled)
    else $error("matching code with flag set did not enable debug");
  flag_refuse_a: assert property (check_fail_s |=> !debug_enabled [*2])
    else $error("debug enabled despite failed check");
  enable_cause_a: assert property ($rose(debug_enabled) |-> $past(s_q.auth, 2) == debug_gate_pkg::AUTH_CHECK
                                   && $past(id_match, 2) && $past(stored_id[79], 2))
    else $error("debug enabled without a matched check");
  flag_bit_a: assert property (!stored_id[`DG_EMU_FLAG_BIT] && s_q.auth == debug_gate_pkg::AUTH_CHECK
                               |=> s_q.auth == debug_gate_pkg::AUTH_DENIED && s_q.fail)
    else $error("cleared emulator flag not honoured");
  break_block_a: assert property (break_req && brk_block |=> !break_grant)
    else $error("forced break granted while blocked");
  mon_block_a: assert property (monitor_req && uart_clock_mismatch && s_q.link == debug_gate_pkg::LINK_UART
                                |=> !monitor_grant)
    else $error("monitor granted with mismatched async clock");
  wake_a: assert property (monitor_req && s_q.auth == debug_gate_pkg::AUTH_OPEN && standby_active
                           && !standby_maskable_wake_off
                           && s_q.link != debug_gate_pkg::LINK_UART |=> standby_wake)
    else $error("monitor request did not wake from standby");
  protect_wr_a: assert property (monitor_req && monitor_write && monitor_target_protected
                                 |=> monitor_write_reject && !monitor_grant)
    else $error("protected write passed the debug path");
  locked_hide_a: assert property (flash_read_req && s_q.auth != debug_gate_pkg::AUTH_OPEN
                                  |=> flash_rdata == 32'h0000_0000
                                  && !break_grant)
    else $error("locked gate leaked flash data or granted break");

endmodule

//--- tb/emu_partner.sv
`timescale 1ns/1ps
// ====================================================================
// Emulator side: debug requests and code entry
module emu_partner (
  input  wire logic aclk,
  output logic      break_req,
  output logic      monitor_req,
  output logic      monitor_write,
  output logic      monitor_target_protected,
  output logic      flash_read_req
);
  initial begin
    {break_req, monitor_req, monitor_write, monitor_target_protected, flash_read_req} = 5'h00;
  end

  // Only requests are driven: no port 9 select bits, no handshake port pin,
  // no monitor flash region and no debug_mode_select_bit writes from here
  // Drives one cycle of requests just after a rising edge
  task automatic send(input logic [4:0] q);
    @(posedge aclk);
    {break_req, monitor_req, monitor_write, monitor_target_protected, flash_read_req} <= q;
  endtask

  // Code asked before any session; twenty hex characters, any case, first pair lowest byte
  function automatic logic [79:0] id_from_hex(input string s);
    logic [79:0] v;
    byte         c;
    v = 80'h0;
    for (int i = 0; i < 20; i++) begin
      c = s[i];
      v[(i / 2) * 8 + ((i % 2) ? 0 : 4) +: 4] = 4'((c >= "a") ? c - 87 : (c >= "A") ? c - 55 : c - 48);
    end
    return v;
  endfunction
endmodule

//--- tb/tb_debug_access_security_gate.sv
`timescale 1ns/1ps
// ====================================================================
// Bench with a behavioural model of the gate
module tb_debug_access_security_gate;
  logic        aclk, aresetn, awv, wv, bre, arv, rre, gid, msk, sb, wo, cr, mm, op, fl;
  logic        awr, wr, bv, arr, rv, den, bg, mg, wrj, wk, fv, brq, mrq, mwr, mpr, frq;
  logic [1:0]  br, rr, lk, tr;
  logic [3:0]  ws;
  logic [4:0]  awa, ara;
  logic [31:0] wd, rd, fdi, fdo, td;
  logic [79:0] sid, sup;
  int          error_cnt, checked;

  debug_access_security_gate u_debug_access_security_gate (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre), .stored_id(sid),
    .global_interrupt_disable(gid), .debug_irq_masked(msk), .standby_active(sb),
    .standby_maskable_wake_off(wo), .main_clock_running(cr), .uart_clock_mismatch(mm),
    .break_req(brq), .monitor_req(mrq), .monitor_write(mwr), .monitor_target_protected(mpr),
    .flash_read_req(frq), .flash_rdata_in(fdi), .debug_enabled(den), .break_grant(bg),
    .monitor_grant(mg), .monitor_write_reject(wrj), .standby_wake(wk), .flash_read_valid(fv),
    .flash_rdata(fdo)
  );

  emu_partner u_emu_partner (
    .aclk(aclk), .break_req(brq), .monitor_req(mrq), .monitor_write(mwr),
    .monitor_target_protected(mpr), .flash_read_req(frq)
  );

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // ====================================================================
  // Compare and bus tasks
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_dbg(input logic [4:0] g, input logic [4:0] e);
    chk_reg({27'h0, g}, {27'h0, e});
  endtask

  task automatic axw(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    {awa, wd, awv, wv, bre} <= {a, d, 3'b111};
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (!bv);
    r = br;
    bre <= 1'b0;
  endtask

  task automatic axr(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    {ara, arv, rre} <= {a, 2'b11};
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    {d, r} = {rd, rr};
    rre <= 1'b0;
  endtask

  // ====================================================================
  // Gate control and debug traffic
  task automatic setid(input logic [79:0] c);
    logic [1:0]  r;
    logic [95:0] w;
    w = {16'h0, c};
    sup = c;
    for (int i = 0; i < 3; i++) begin
      axw(5'(4 + 4 * i), w[32 * i +: 32], r);
      chk_reg({30'h0, r}, 32'h0);
    end
  endtask

  task automatic ctrl(input logic [31:0] v);
    logic [31:0] d;
    logic [1:0]  r;
    logic        bb, mb;
    axw(5'h00, v, r);
    chk_reg({30'h0, r}, 32'h0);
    if (v[0]) begin
      op = (sup === sid) && sid[79];
      fl = fl || !op;
    end else begin
      op = op && !v[1];
      fl = fl && !v[2];
    end
    lk = v[5:4];
    repeat (3) @(posedge aclk);
    axr(5'h10, d, r);
    bb = gid || msk || (sb && wo) || (lk == 2'h2 && !cr);
    mb = bb || (lk == 2'h2 && mm);
    chk_reg(d & 32'h0000_003F, {26'h0, !mb, !bb, fl, op, sid[79], op});
    axr(5'h00, d, r);
    chk_reg(d, {26'h0, lk, 4'h0});
    @(negedge aclk);
    chk_dbg({4'h0, den}, {4'h0, op});
  endtask

  task automatic traffic(input int n);
    logic [4:0]  e;
    logic [31:0] fe;
    logic        pf, blk;
    for (int i = 0; i <= n; i++) begin
      u_emu_partner.send((i < n) ? 5'($urandom) : 5'h00);
      {gid, msk, sb, wo, mm} <= 5'($urandom & $urandom);
      cr <= ($urandom % 4) != 0;
      fdi <= $urandom;
      @(negedge aclk);
      if (i > 0) begin
        chk_dbg({fv, wk, wrj, mg, bg}, e);
        if (pf) chk_reg(fdo, fe);
      end
      blk = gid || msk || (sb && wo) || (lk == 2'h2 && !cr);
      e = {frq, mrq && op && sb && !wo && (lk != 2'h2 || cr), mrq && mwr && mpr,
           mrq && op && !blk && !(lk == 2'h2 && mm) && !(mwr && mpr), brq && op && !blk};
      fe = op ? fdi : 32'h0;
      pf = frq;
    end
  endtask

  task automatic wrap_up;
    $display("mismatches=%0d comparisons=%0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #(20 * 30000);
    error_cnt++;
    wrap_up;
  end

  // ====================================================================
  // Main sequence
  initial begin
    {aresetn, awv, wv, bre, arv, rre, gid, msk, sb, wo, mm, op, fl} = 13'h0000;
    {awa, ara, wd, fdi, lk, sup} = '0;
    {ws, cr} = 5'h1F;
    error_cnt = 0;
    checked = 0;
    void'($urandom(32'h2B56));
    sid = u_emu_partner.id_from_hex("123456789abcdef123D4");
    chk_reg(sid[31:0], 32'h7856_3412);
    chk_reg({16'h0, sid[79:64]}, 32'h0000_D423);
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk_dbg({den, awr, wr, arr, bv}, 5'h0E);
    axr(5'h14, td, tr);
    chk_reg({tr, td[29:0]}, 32'h8000_0000);
    axw(5'h18, 32'hFFFF_FFFF, tr);
    chk_reg({30'h0, tr}, 32'h2);
    traffic(100);
    setid(sid ^ 80'h1);
    ctrl(32'h1);
    ctrl(32'h4);
    sid[79] = 1'b0;
    setid(sid);
    ctrl(32'h1);
    ctrl(32'h4);
    sid[79] = 1'b1;
    setid(sid);
    ctrl(32'h1);
    for (int l = 0; l < 3; l++) begin
      ctrl({26'h0, 2'(l), 4'h0});
      traffic(300);
    end
    ctrl(32'h2);
    traffic(50);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    {op, fl, lk} = 4'h0;
    ctrl(32'h0);
    wrap_up;
  end
endmodule
